/* include/ccrc_pkg.sv */
// Constants, types and helpers of the codec control bank with TDM cascade
// How it works
// - Volume code n gives gain (n+1)/1024
// - Peak in bits 9..4, low four zero
// - Bit 8 replicates pair one; bits 7..0 mute
// - Control one: dither, filter, power-down, rate
// - Control two: aux master bit, format field, word width, right and left mutes
// - Control three: clock scale, peak enable, test zero
// - Select pin low master, high slave
// - Master drives frame sync and bit clock
// - Each codec is a chained 256-bit shifter
// - Frame start loads previous ADC results
// - Shift out to host, shift in from slave
// - Frame end: 512 bits replaced, DAC update
// - Reading a peak register clears it
// - Volumes reset to 1023
package ccrc_pkg;
	// ----------------------------------------------------------------
	// Register map: index in word address bits, read flag above it
	// ----------------------------------------------------------------
	localparam int IDX_W = 4;
	localparam int DATA_W = 10;
	localparam int IDX_LSB = 2;
	localparam int RDFLAG_BIT = 6;
	localparam int WORD_ADDR_LSB = 12;
	localparam int WORD_RD_BIT = 11;
	localparam logic [IDX_W-1:0] IDX_MUTE = 4'h1;
	localparam logic [IDX_W-1:0] IDX_VOL_FIRST = 4'h2;
	localparam logic [IDX_W-1:0] IDX_VOL_LAST = 4'h9;
	localparam logic [IDX_W-1:0] IDX_PEAK_L = 4'h2;
	localparam logic [IDX_W-1:0] IDX_PEAK_R = 4'hb;
	localparam logic [IDX_W-1:0] IDX_ADC1 = 4'hc;
	localparam logic [IDX_W-1:0] IDX_ADC2 = 4'hd;
	localparam logic [IDX_W-1:0] IDX_ADC3 = 4'he;
	// ----------------------------------------------------------------
	// Fields, writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] VOL_RESET = 10'h3ff;
	localparam logic [DATA_W-1:0] CTRL_RESET = 10'h000;
	localparam logic [DATA_W-1:0] MUTE_MASK = 10'h1ff;
	localparam logic [DATA_W-1:0] ADC1_MASK = 10'h3c0;
	localparam logic [DATA_W-1:0] ADC2_MASK = 10'h3f3;
	localparam logic [DATA_W-1:0] ADC3_MASK = 10'h0e0;
	localparam int PEAK_W = 6;
	localparam int PEAK_LSB = 4;
	localparam int REPL_BIT = 8;
	localparam int FMT_LSB = 6;
	localparam int PEAK_EN_BIT = 5;
	localparam logic [2:0] FMT_AUX512 = 3'h7;
	// ----------------------------------------------------------------
	// Cascade frame
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 256;
	localparam int CHAIN_BITS = 512;
	localparam int CNT_W = 9;
	localparam int SLOT_W = 32;
	localparam int SAMPLE_W = 24;
	localparam int CHANNELS = 8;
	localparam int SYNC_N = 4;

	typedef enum logic {LS_IDLE, LS_RUN} ccrc_link_state_type;

	typedef struct packed {
		logic dither;
		logic high_pass;
		logic adc_power_down;
		logic rate_96k;
		logic aux_master;
		logic [2:0] format;
		logic [1:0] word_width;
		logic mute_right;
		logic mute_left;
		logic [1:0] internal_core_clock;
		logic peak_enable;
	} ccrc_adc_ctrl_type;

	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} ccrc_adc_pair_type;

	// Linear gain of (code+1)/1024 on a signed sample
	function automatic logic [SAMPLE_W-1:0] ccrc_scale(
		input logic [SAMPLE_W-1:0] s, input logic [DATA_W-1:0] v);
		logic signed [35:0] p;
		p = 36'($signed(s)) * 36'($signed({2'h0, v} + 12'h001));
		return p[SAMPLE_W+DATA_W-1:DATA_W];
	endfunction
endpackage

/* hw/ccrc_top.sv */
// Codec control bank on APB with the two-device TDM cascade link
`timescale 1ns/1ps
module ccrc_top (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic adc_valid_i,
	input wire ccrc_pkg::ccrc_adc_pair_type adc_sample_i,
	input wire logic [ccrc_pkg::PEAK_W-1:0] peak_att_left_i,
	input wire logic [ccrc_pkg::PEAK_W-1:0] peak_att_right_i,
	output ccrc_pkg::ccrc_adc_ctrl_type adc_ctrl_o,
	output logic [ccrc_pkg::CHANNELS-1:0][ccrc_pkg::SAMPLE_W-1:0] dac_o,
	output logic dac_valid_o,
	input wire logic link_clk_i,
	input wire logic master_slave_sel_i,
	input wire logic powerdown_reset_pin_n_i,
	input wire logic fsync_i,
	output logic fsync_o,
	output logic fsync_oe_o,
	output logic bclk_o,
	output logic bclk_oe_o,
	input wire logic sdata_i,
	output logic sdata_o
);
	import ccrc_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mute_r;
	logic [DATA_W-1:0] vol_r [CHANNELS];
	logic [DATA_W-1:0] adc1_r, adc2_r, adc3_r;
	logic [PEAK_W-1:0] peak_l_r, peak_r_r;
	logic seen_l_r, seen_r_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;
	ccrc_adc_pair_type adc_pair_r;
	logic adc_tgl_r;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire [IDX_W-1:0] idx = paddr_i[IDX_LSB +: IDX_W];
	wire rd_flag = paddr_i[RDFLAG_BIT];
	wire setup = psel_i && !penable_i;
	wire access = psel_i && penable_i && pready_r;
	wire is_vol = !rd_flag && idx >= IDX_VOL_FIRST && idx <= IDX_VOL_LAST;
	wire [2:0] vol_sel = 3'(idx - IDX_VOL_FIRST);
	wire is_peak_l = rd_flag && idx == IDX_PEAK_L;
	wire is_peak_r = rd_flag && idx == IDX_PEAK_R;
	wire is_mute = !rd_flag && idx == IDX_MUTE;
	wire is_adc1 = !rd_flag && idx == IDX_ADC1;
	wire is_adc2 = !rd_flag && idx == IDX_ADC2;
	wire is_adc3 = !rd_flag && idx == IDX_ADC3;
	wire peak_hit = is_peak_l || is_peak_r;
	wire mapped = is_vol || is_mute || is_adc1 || is_adc2 || is_adc3 ||
		(peak_hit && !pwrite_i);
	wire wr = access && pwrite_i && !pslverr_r;
	wire [DATA_W-1:0] wdata = pwdata_i[DATA_W-1:0];
	wire [DATA_W-1:0] peak_word_l = {peak_l_r, 4'h0};
	wire [DATA_W-1:0] peak_word_r = {peak_r_r, 4'h0};
	logic [DATA_W-1:0] rsel;
	always_comb begin
		if (is_vol) begin
			rsel = vol_r[vol_sel];
		end else if (is_mute) begin
			rsel = mute_r;
		end else if (is_adc1) begin
			rsel = adc1_r;
		end else if (is_adc2) begin
			rsel = adc2_r;
		end else if (is_adc3) begin
			rsel = adc3_r;
		end else if (is_peak_l) begin
			rsel = peak_word_l;
		end else if (is_peak_r) begin
			rsel = peak_word_r;
		end else begin
			rsel = CTRL_RESET;
		end
	end
	// Read data laid out as a control word
	wire [31:0] rword = {16'h0, idx, rd_flag, 1'b0, rsel};

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && !mapped;
			prdata_r <= (setup && mapped && !pwrite_i) ? rword : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Control registers, reserved bits held at zero
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mute_r <= CTRL_RESET;
			adc1_r <= CTRL_RESET;
			adc2_r <= CTRL_RESET;
			adc3_r <= CTRL_RESET;
			for (int i = 0; i < CHANNELS; i++) begin
				vol_r[i] <= VOL_RESET;
			end
		end else if (wr) begin
			if (is_mute) begin
				mute_r <= wdata & MUTE_MASK;
			end
			if (is_adc1) begin
				adc1_r <= wdata & ADC1_MASK;
			end
			if (is_adc2) begin
				adc2_r <= wdata & ADC2_MASK;
			end
			if (is_adc3) begin
				adc3_r <= wdata & ADC3_MASK;
			end
			if (is_vol) begin
				vol_r[vol_sel] <= wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Peak hold: read clears, a new sample that updates the hold in that cycle wins
	// ----------------------------------------------------------------
	wire peak_en = adc3_r[PEAK_EN_BIT];
	wire upd_l = peak_en && adc_valid_i &&
		(!seen_l_r || peak_att_left_i < peak_l_r);
	wire upd_r = peak_en && adc_valid_i &&
		(!seen_r_r || peak_att_right_i < peak_r_r);
	wire clr_l = access && !pwrite_i && is_peak_l;
	wire clr_r = access && !pwrite_i && is_peak_r;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			peak_l_r <= '0;
			peak_r_r <= '0;
			seen_l_r <= 1'b0;
			seen_r_r <= 1'b0;
		end else begin
			if (upd_l) begin
				peak_l_r <= peak_att_left_i;
				seen_l_r <= 1'b1;
			end else if (clr_l) begin
				peak_l_r <= '0;
				seen_l_r <= 1'b0;
			end
			if (upd_r) begin
				peak_r_r <= peak_att_right_i;
				seen_r_r <= 1'b1;
			end else if (clr_r) begin
				peak_r_r <= '0;
				seen_r_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// ADC sample hand-over to the link domain
	// ----------------------------------------------------------------
	logic cas_en_r;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			adc_pair_r <= '0;
			adc_tgl_r <= 1'b0;
			cas_en_r <= 1'b0;
		end else begin
			cas_en_r <= adc2_r[FMT_LSB +: 3] == FMT_AUX512;
			if (adc_valid_i) begin
				adc_pair_r <= adc_sample_i;
				adc_tgl_r <= ~adc_tgl_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	logic [SYNC_N+1:0] ls1_r, ls2_r;
	logic fs_d_r, adc_tgl_d_r, ph_r, fsync_r, sdo_r, dac_tgl_r, oe_r;
	logic [CNT_W-1:0] cnt_r;
	logic [FRAME_BITS-1:0] sh_r, dac_hold_r;
	ccrc_adc_pair_type adc_link_r;
	ccrc_link_state_type ls_r;
	// Pin inputs, clock-domain enable and sample toggle, two stages
	wire [SYNC_N+1:0] ls_in = {adc_tgl_r, cas_en_r, fsync_i, sdata_i,
		powerdown_reset_pin_n_i, master_slave_sel_i};
	wire ms_s = ls2_r[0];
	wire pd_n_s = ls2_r[1];
	wire sdi_s = ls2_r[2];
	wire fs_s = ls2_r[3];
	wire en_s = ls2_r[4];
	wire tgl_s = ls2_r[5];
	wire is_master = !ms_s;
	wire run_ok = en_s && pd_n_s;
	wire shift = ls_r == LS_RUN && ph_r;
	wire m_start = is_master && shift && cnt_r == 9'(CHAIN_BITS - 1);
	wire s_start = !is_master && ls_r == LS_RUN && fs_s && !fs_d_r;
	wire start = m_start || s_start;
	wire [FRAME_BITS-1:0] adc_frame = {adc_link_r.left, 8'h0,
		adc_link_r.right, 8'h0, {(FRAME_BITS - 2*SLOT_W){1'b0}}};

	always_ff @(posedge link_clk_i) begin
		ls1_r <= ls_in;
		ls2_r <= ls1_r;
	end

	always_ff @(posedge link_clk_i) begin
		if (!pd_n_s) begin
			ls_r <= LS_IDLE;
			ph_r <= 1'b0;
			cnt_r <= '0;
			fsync_r <= 1'b0;
			fs_d_r <= 1'b0;
			adc_tgl_d_r <= 1'b0;
			adc_link_r <= '0;
			oe_r <= 1'b0;
		end else begin
			fs_d_r <= fs_s;
			oe_r <= is_master && ls_r == LS_RUN;
			adc_tgl_d_r <= tgl_s;
			if (tgl_s != adc_tgl_d_r) begin
				adc_link_r <= adc_pair_r;
			end
			case (ls_r)
				LS_IDLE: begin
					ph_r <= 1'b0;
					cnt_r <= '0;
					fsync_r <= 1'b0;
					if (run_ok) begin
						ls_r <= LS_RUN;
					end
				end
				LS_RUN: begin
					ph_r <= ~ph_r;
					if (shift) begin
						cnt_r <= 9'(cnt_r + 9'h001);
						fsync_r <= m_start;
					end
					if (s_start) begin
						cnt_r <= '0;
					end
					if (!run_ok) begin
						ls_r <= LS_IDLE;
					end
				end
				default: ls_r <= LS_IDLE;
			endcase
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (!pd_n_s) begin
			sh_r <= '0;
			sdo_r <= 1'b0;
			dac_hold_r <= '0;
			dac_tgl_r <= 1'b0;
		end else if (start) begin
			dac_hold_r <= sh_r;
			dac_tgl_r <= ~dac_tgl_r;
			sh_r <= adc_frame;
			sdo_r <= adc_frame[FRAME_BITS-1];
		end else if (shift) begin
			sh_r <= {sh_r[FRAME_BITS-2:0], sdi_s};
			sdo_r <= sh_r[FRAME_BITS-2];
		end
	end

	// ----------------------------------------------------------------
	// DAC frame hand-over, replicate, mute and volume
	// ----------------------------------------------------------------
	logic dt1_r, dt2_r, dt3_r, dac_valid_r;
	logic [CHANNELS-1:0][SAMPLE_W-1:0] dac_r;
	logic [CHANNELS-1:0][SAMPLE_W-1:0] dac_nxt;
	always_comb begin
		for (int k = 0; k < CHANNELS; k++) begin
			automatic int src;
			src = mute_r[REPL_BIT] ? (k % 2) : k;
			dac_nxt[k] = mute_r[k] ? '0 : ccrc_scale(
				dac_hold_r[FRAME_BITS-1-src*SLOT_W -: SAMPLE_W], vol_r[k]);
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dt1_r <= 1'b0;
			dt2_r <= 1'b0;
			dt3_r <= 1'b0;
			dac_valid_r <= 1'b0;
			dac_r <= '0;
		end else begin
			dt1_r <= dac_tgl_r;
			dt2_r <= dt1_r;
			dt3_r <= dt2_r;
			dac_valid_r <= dt2_r != dt3_r;
			if (dt2_r != dt3_r) begin
				dac_r <= dac_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign dac_o = dac_r;
	assign dac_valid_o = dac_valid_r;
	assign adc_ctrl_o = {adc1_r[9:6], adc2_r[9:4], adc2_r[1:0], adc3_r[7:5]};
	assign fsync_o = fsync_r;
	assign fsync_oe_o = oe_r;
	assign bclk_o = ph_r;
	assign bclk_oe_o = oe_r;
	assign sdata_o = sdo_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_vol_reset_val: assert property (@(posedge clk_i)
		!$past(rstn_i) && rstn_i |-> vol_r[0] == VOL_RESET && vol_r[7] == VOL_RESET)
		else $error("volume not at full scale after reset");
	a_peak_low_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		pready_r && $past(peak_hit) |-> prdata_r[PEAK_LSB-1:0] == 4'h0)
		else $error("peak low bits not zero");
	a_peak_read_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clr_l && !upd_l |=> peak_l_r == '0 && !seen_l_r)
		else $error("peak not cleared by read");
	a_mute_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mute_r[DATA_W-1] == 1'b0) else $error("mute reserved bit set");
	a_adc1_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
		adc1_r[5:0] == 6'h00) else $error("control one reserved bits set");
	a_test_field_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		adc3_r[1:0] == 2'h0) else $error("test field not normal");
	a_vol_write_lands: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && is_vol |=> vol_r[$past(vol_sel)] == $past(wdata))
		else $error("volume write lost");
	a_fmt_to_port: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && is_adc2 |=> adc_ctrl_o.format == $past(wdata[FMT_LSB +: 3]))
		else $error("format not on port");
	a_master_drives: assert property (@(posedge link_clk_i)
		disable iff (!pd_n_s) ls_r == LS_RUN ##1 ls_r == LS_RUN |->
		fsync_oe_o == !$past(ms_s))
		else $error("frame sync drive wrong for role");
	a_frame_length: assert property (@(posedge link_clk_i)
		disable iff (!pd_n_s) m_start |=> cnt_r == '0 ##1 cnt_r == '0)
		else $error("master frame not 512 bits");
	a_frame_load: assert property (@(posedge link_clk_i)
		disable iff (!pd_n_s) start |=> sh_r == $past(adc_frame) &&
		dac_hold_r == $past(sh_r)) else $error("frame load wrong");
	a_shift_chain: assert property (@(posedge link_clk_i)
		disable iff (!pd_n_s) shift && !start |=> sh_r[0] == $past(sdi_s) &&
		sdo_r == $past(sh_r[FRAME_BITS-2])) else $error("chain shift wrong");
endmodule

/* test/ccrc_host_model.sv */
// Host serial port and slave codec stand-in on the cascade link
`timescale 1ns/1ps
module ccrc_host_model (
	input wire logic link_clk_i,
	input wire logic run_i,
	input wire logic fsync_i,
	input wire logic bclk_i,
	input wire logic sdata_i,
	output logic sdata_o,
	output int period_o,
	output int ones_o
);
	logic fs_q = 1'b0;
	logic idle_q = 1'b0;
	int cnt = 0;
	int acc = 0;
	int bit_one;
	assign bit_one = (!bclk_i && sdata_i) ? 1 : 0;
	// --------------------------------------------------------------
	// DAC data: all ones in frames, toggling while the link idles
	// --------------------------------------------------------------
	assign sdata_o = run_i ? 1'b1 : idle_q;
	// --------------------------------------------------------------
	// Frame period and count of ones seen between frame syncs
	// --------------------------------------------------------------
	always @(posedge link_clk_i) begin
		fs_q <= fsync_i;
		idle_q <= ~idle_q;
		if (fsync_i && !fs_q) begin
			period_o <= cnt;
			ones_o <= acc;
			cnt <= 1;
			acc <= bit_one;
		end else begin
			cnt <= cnt + 1;
			acc <= acc + bit_one;
		end
	end
endmodule

/* test/ccrc_top_tb.sv */
// Self-checking bench of the codec control bank and cascade link
`timescale 1ns/1ps
module ccrc_top_tb;
	import ccrc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, dac_valid, err;
	logic adc_valid = 1'b0;
	logic link_clk = 1'b0;
	logic pin_n = 1'b0;
	logic ms_sel = 1'b0;
	logic fsync, fsync_oe, bclk, bclk_oe, sd_in, sd_out;
	ccrc_adc_pair_type adc_sample = {24'hffffff, 24'hffffff};
	logic [5:0] peak_l = 6'h00;
	logic [5:0] peak_r = 6'h00;
	ccrc_adc_ctrl_type adc_ctrl;
	logic [CHANNELS-1:0][SAMPLE_W-1:0] dac;
	logic [31:0] rd;
	int period, ones;
	int fail_count = 0;
	int comparisons = 0;
	always #2 clk = ~clk;
	initial begin
		#1.7;
		forever #6 link_clk = ~link_clk;
	end
	ccrc_top uut (.clk_i(clk), .rstn_i(rstn), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .adc_valid_i(adc_valid),
		.adc_sample_i(adc_sample), .peak_att_left_i(peak_l),
		.peak_att_right_i(peak_r), .adc_ctrl_o(adc_ctrl), .dac_o(dac),
		.dac_valid_o(dac_valid), .link_clk_i(link_clk),
		.master_slave_sel_i(ms_sel), .powerdown_reset_pin_n_i(pin_n),
		.fsync_i(1'b0), .fsync_o(fsync), .fsync_oe_o(fsync_oe),
		.bclk_o(bclk), .bclk_oe_o(bclk_oe), .sdata_i(sd_in),
		.sdata_o(sd_out));
	ccrc_host_model partner (.link_clk_i(link_clk), .run_i(fsync_oe),
		.fsync_i(fsync), .bclk_i(bclk), .sdata_i(sd_out),
		.sdata_o(sd_in), .period_o(period), .ones_o(ones));
	// --------------------------------------------------------------
	// Checking and closing
	// --------------------------------------------------------------
	task finish_test;
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// --------------------------------------------------------------
	// Bus and stimulus tasks, entered just after a rising edge
	// --------------------------------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		chk({31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rdx(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, e});
	endtask
	task adc_pulse(input logic [5:0] l, input logic [5:0] r);
		peak_l <= l;
		peak_r <= r;
		adc_valid <= 1'b1;
		@(posedge clk);
		adc_valid <= 1'b0;
		repeat (16) @(posedge clk);
	endtask
	task wait_dac;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dac_valid !== 1'b1 && n < 8000);
		chk({31'h0, dac_valid}, 32'h1);
	endtask
	// --------------------------------------------------------------
	// Test sequence
	// --------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
		pin_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rdx(8'(8 + 4 * i), {16'h0, 4'(i + 2), 12'h3ff}, 1'b0);
		end
		rdx(8'h04, 32'h1000, 1'b0);
		chk({17'h0, adc_ctrl}, 32'h0);
		chk({31'h0, fsync_oe}, 32'h0);
		apb(1'b1, 8'h04, 32'h3ff);
		rdx(8'h04, 32'h11ff, 1'b0);
		apb(1'b1, 8'h30, 32'h3ff);
		rdx(8'h30, 32'hc3c0, 1'b0);
		apb(1'b1, 8'h38, 32'h3ff);
		rdx(8'h38, 32'he0e0, 1'b0);
		apb(1'b1, 8'h34, 32'h3ff);
		rdx(8'h34, 32'hd3f3, 1'b0);
		chk({17'h0, adc_ctrl}, 32'h7fff);
		apb(1'b1, 8'h14, 32'h155);
		rdx(8'h14, 32'h5155, 1'b0);
		rdx(8'h00, 32'h0, 1'b1);
		rdx(8'h28, 32'h0, 1'b1);
		rdx(8'h3c, 32'h0, 1'b1);
		rdx(8'h4c, 32'h0, 1'b1);
		apb(1'b1, 8'h48, 32'h3ff);
		chk({31'h0, err}, 32'h1);
		adc_pulse(6'h05, 6'h07);
		adc_pulse(6'h09, 6'h07);
		adc_pulse(6'h03, 6'h09);
		rdx(8'h48, 32'h2830, 1'b0);
		rdx(8'h6c, 32'hb870, 1'b0);
		rdx(8'h48, 32'h2800, 1'b0);
		repeat (4) wait_dac;
		chk(32'(period), 32'd1024);
		chk(32'(ones), 32'd304);
		chk({30'h0, fsync_oe, bclk_oe}, 32'h3);
		apb(1'b1, 8'h04, 32'h1a5);
		repeat (2) wait_dac;
		for (int k = 0; k < 8; k++) begin
			chk({8'h0, dac[k]}, k[0] ^ k[2] ? 32'hffffff : 32'h0);
		end
		apb(1'b1, 8'h34, 32'h000);
		repeat (40) @(posedge clk);
		chk({30'h0, fsync_oe, bclk_oe}, 32'h0);
		ms_sel <= 1'b1;
		apb(1'b1, 8'h34, 32'h1c0);
		repeat (40) @(posedge clk);
		chk({30'h0, fsync_oe, bclk_oe}, 32'h0);
		finish_test;
	end
	initial begin
		#200000;
		fail_count++;
		$display("mismatch at %0t: got %h expected %h", $time, 0, 1);
		finish_test;
	end
endmodule
